// ---- logic/acr_pkg.sv ----
/*
 converter control package: register offsets, field positions, reset values,
 conversion lengths and state encoding.
 assumes a 32-bit apb slave with one aligned word per register.
*/
package acr_pkg;
   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [11:0] ACR_OFS_INPUT_SELECT = 12'h000;
   localparam logic [11:0] ACR_OFS_CONTROL = 12'h004;
   localparam logic [11:0] ACR_OFS_RESULT_LOW = 12'h008;
   localparam logic [11:0] ACR_OFS_RESULT_HIGH = 12'h00C;
   localparam logic [11:0] ACR_OFS_INT_CTRL = 12'h010;
   // ****************************************
   // field positions
   // ****************************************
   localparam int ACR_REF_MSB = 7;
   localparam int ACR_REF_LSB = 6;
   localparam int ACR_LEFT_ALIGN_BIT = 5;
   localparam int ACR_CH_MSB = 3;
   localparam int ACR_ENABLE_BIT = 7;
   localparam int ACR_START_BIT = 6;
   localparam int ACR_FREE_RUN_BIT = 5;
   localparam int ACR_DONE_BIT = 4;
   localparam int ACR_IRQ_EN_BIT = 3;
   localparam int ACR_DIV_MSB = 2;
   localparam int ACR_GIE_BIT = 0;
   localparam int ACR_VEC_ACK_BIT = 1;
   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [7:0] ACR_RST_INPUT_SELECT = 8'h00;
   localparam logic [7:0] ACR_RST_CONTROL = 8'h00;
   localparam logic [9:0] ACR_RST_RESULT = 10'h000;
   localparam logic [4:0] ACR_FIRST_CONV_CYCLES = 5'd25;
   localparam logic [4:0] ACR_NORMAL_CONV_CYCLES = 5'd13;
   localparam logic [1:0] ACR_REF_EXTERNAL = 2'b00;
   localparam logic [1:0] ACR_REF_SUPPLY = 2'b01;
   localparam logic [1:0] ACR_REF_INTERNAL = 2'b11;
   localparam logic [3:0] ACR_CH_BANDGAP = 4'hE;
   localparam logic [3:0] ACR_CH_GROUND = 4'hF;
   typedef enum logic [1:0] {
      ACR_ST_IDLE = 2'b01,
      ACR_ST_CONV = 2'b10
   } acr_state_e;
endpackage

// ---- logic/acr_clk_div.sv ----
/*
 converter clock prescaler: one-cycle tick at system clock / divisor.
 assumes the divider code may change at any time; count restarts cleanly.
*/
module acr_clk_div
   import acr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_run,
   input wire logic [2:0] i_div_sel,
   output logic o_tick
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [6:0] last;
   // codes 0 and 1 both divide by 2, then doubling up to 128
   always_comb begin
      last = (i_div_sel == 3'd0) ? 7'd1 : 7'((8'd1 << i_div_sel) - 8'd1);
      cnt_d = (!i_run || cnt_q >= last) ? 7'd0 : 7'(cnt_q + 7'd1);
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= 7'd0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign o_tick = i_run && (cnt_q >= last);
   // after a tick at divide by 4, three quiet cycles and then the next tick
   AST_TICK_PERIOD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      o_tick && i_div_sel == 3'd2 ##1 (i_run && i_div_sel == 3'd2)[*4]
      |-> o_tick && !$past(o_tick) && !$past(o_tick, 2) && !$past(o_tick, 3))
      else $error("divide by 4 tick spacing wrong");
endmodule

// ---- logic/acr_result_view.sv ----
/*
 result formatter: maps the 10-bit code onto the two byte views.
 assumes purely combinational use by the register read mux.
*/
module acr_result_view
   import acr_pkg::*;
(
   input wire logic [9:0] i_code,
   input wire logic i_left_align,
   output logic [7:0] o_high,
   output logic [7:0] o_low
);
   // unsigned code, 0 is ground, all ones is reference minus one step
   always_comb begin
      if (i_left_align) begin
         o_high = i_code[9:2];
         o_low = {i_code[1:0], 6'h00};
      end else begin
         o_high = {6'h00, i_code[9:8]};
         o_low = i_code[7:0];
      end
   end
endmodule

// ---- logic/acr_top.sv ----
/*
 converter control and result registers behind an apb slave.
 assumes the analog core samples o_conv_* and presents i_sar_code at end of
 each conversion; the processor core supplies global enable and vector ack.
*/
// Design decisions made here: the APB register port and the register offsets.
// Functional notes
// - reference field bits 7:6 decoded
// - selection latched for running conversion
// - align bit 5 reformats result immediately
// - channel field bits 3:0 decoded
// - enable powers converter, clear aborts
// - start write begins conversion
// - first conversion 25 cycles, else 13
// - start reads one while converting
// - free running converts back to back
// - done flag set on every completion
// - interrupt when flag, enable, global set
// - flag cleared by vector or write-one
// - prescaler divides system clock 2..128
// - byte views per alignment, rest zero
// - low read locks result until high
// - free-run channel change hits conversion after
// - unsigned ten-bit result codes
module acr_top
   import acr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [9:0] i_sar_code,
   input wire logic i_irq_vector_ack,
   output logic o_conv_power,
   output logic o_conv_clk_tick,
   output logic o_conv_sample,
   output logic [1:0] o_conv_ref_sel,
   output logic o_conv_ref_internal_on,
   output logic [3:0] o_conv_channel,
   output logic o_conv_channel_valid,
   output logic o_conv_irq
);
   // ****************************************
   // state
   // ****************************************
   acr_state_e st_q, st_d;
   logic [7:0] sel_q, sel_d;
   logic [7:0] ctl_q, ctl_d;
   logic [9:0] res_q, res_d;
   logic [1:0] act_ref_q, act_ref_d;
   logic [3:0] act_ch_q, act_ch_d;
   logic [4:0] cyc_q, cyc_d;
   logic [4:0] len_q, len_d;
   logic init_q, init_d;
   logic lock_q, lock_d;
   logic gie_q, gie_d;
   logic [31:0] rdata_q, rdata_d;
   logic tick;
   logic [7:0] view_hi, view_lo;
   logic acc, wr, rd, mapped, done_ev, start_req;
   // ****************************************
   // apb decode
   // ****************************************
   // zero-wait slave: every access completes in its first access cycle
   assign acc = i_psel && i_penable;
   assign wr = acc && i_pwrite;
   assign rd = acc && !i_pwrite;
   function automatic logic is_mapped(input logic [11:0] a);
      return a == ACR_OFS_INPUT_SELECT || a == ACR_OFS_CONTROL || a == ACR_OFS_RESULT_LOW
         || a == ACR_OFS_RESULT_HIGH || a == ACR_OFS_INT_CTRL;
   endfunction
   assign mapped = is_mapped(i_paddr);
   assign o_pready = 1'b1;
   assign o_pslverr = acc && !mapped;
   assign o_prdata = rdata_q;
   acr_clk_div u_div (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_run(ctl_q[ACR_ENABLE_BIT]),
      .i_div_sel(ctl_q[ACR_DIV_MSB:0]),
      .o_tick(tick)
   );
   acr_result_view u_view (
      .i_code(res_q),
      .i_left_align(sel_q[ACR_LEFT_ALIGN_BIT]),
      .o_high(view_hi),
      .o_low(view_lo)
   );
   // ****************************************
   // conversion sequencing
   // ****************************************
   assign done_ev = (st_q == ACR_ST_CONV) && tick && (cyc_q == len_q - 5'd1);
   always_comb begin
      logic wr_ctl;
      wr_ctl = wr && i_paddr == ACR_OFS_CONTROL;
      st_d = st_q;
      cyc_d = cyc_q;
      len_d = len_q;
      init_d = init_q;
      act_ref_d = act_ref_q;
      act_ch_d = act_ch_q;
      sel_d = sel_q;
      ctl_d = ctl_q;
      res_d = res_q;
      lock_d = lock_q;
      gie_d = gie_q;
      start_req = 1'b0;
      if (wr && i_paddr == ACR_OFS_INPUT_SELECT) begin
         sel_d = i_pwdata[7:0] & 8'hEF;
      end
      if (wr && i_paddr == ACR_OFS_INT_CTRL) begin
         gie_d = i_pwdata[ACR_GIE_BIT];
      end
      if (wr_ctl) begin
         ctl_d[ACR_ENABLE_BIT] = i_pwdata[ACR_ENABLE_BIT];
         ctl_d[ACR_FREE_RUN_BIT] = i_pwdata[ACR_FREE_RUN_BIT];
         ctl_d[ACR_IRQ_EN_BIT] = i_pwdata[ACR_IRQ_EN_BIT];
         ctl_d[ACR_DIV_MSB:0] = i_pwdata[ACR_DIV_MSB:0];
         start_req = i_pwdata[ACR_START_BIT]; // writing zero has no effect
      end
      // enable rising re-arms the long initialising conversion
      if (wr_ctl && i_pwdata[ACR_ENABLE_BIT] && !ctl_q[ACR_ENABLE_BIT]) begin
         init_d = 1'b1;
      end
      // both clear paths act first, so a same-cycle completion sets the flag again
      if ((wr_ctl && i_pwdata[ACR_DONE_BIT]) || i_irq_vector_ack) begin
         ctl_d[ACR_DONE_BIT] = 1'b0;
      end
      // low byte read arms the lock, high byte read releases it
      if (rd && i_paddr == ACR_OFS_RESULT_LOW) begin
         lock_d = 1'b1;
      end
      if (rd && i_paddr == ACR_OFS_RESULT_HIGH) begin
         lock_d = 1'b0;
      end
      unique case (st_q)
         ACR_ST_IDLE: begin
            if (start_req && ctl_d[ACR_ENABLE_BIT]) begin
               st_d = ACR_ST_CONV;
               cyc_d = 5'd0;
               len_d = init_d ? ACR_FIRST_CONV_CYCLES : ACR_NORMAL_CONV_CYCLES;
               init_d = 1'b0;
               act_ref_d = sel_d[ACR_REF_MSB:ACR_REF_LSB];
               act_ch_d = sel_d[ACR_CH_MSB:0];
            end
         end
         ACR_ST_CONV: begin
            if (tick) begin
               cyc_d = 5'(cyc_q + 5'd1);
            end
            if (done_ev) begin
               if (!lock_q) begin
                  res_d = i_sar_code;
               end
               ctl_d[ACR_DONE_BIT] = 1'b1; // locked result dropped, flag still set
               if (ctl_q[ACR_FREE_RUN_BIT]) begin
                  cyc_d = 5'd0; // next conversion starts at once
                  len_d = ACR_NORMAL_CONV_CYCLES;
                  act_ref_d = sel_q[ACR_REF_MSB:ACR_REF_LSB];
                  act_ch_d = sel_q[ACR_CH_MSB:0];
               end else begin
                  st_d = ACR_ST_IDLE;
               end
            end
         end
      endcase
      if (!ctl_d[ACR_ENABLE_BIT]) begin
         st_d = ACR_ST_IDLE; // abort on disable
         cyc_d = 5'd0;
      end
      ctl_d[ACR_START_BIT] = (st_d == ACR_ST_CONV);
   end
   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      rdata_d = rdata_q;
      if (i_psel && !i_penable && !i_pwrite) begin
         unique case (i_paddr)
            ACR_OFS_INPUT_SELECT: rdata_d = {24'h0000_00, sel_q};
            ACR_OFS_CONTROL: rdata_d = {24'h0000_00, ctl_q};
            ACR_OFS_RESULT_LOW: rdata_d = {24'h0000_00, view_lo};
            ACR_OFS_RESULT_HIGH: rdata_d = {24'h0000_00, view_hi};
            ACR_OFS_INT_CTRL: rdata_d = {31'h0000_0000, gie_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= ACR_ST_IDLE;
         sel_q <= ACR_RST_INPUT_SELECT;
         ctl_q <= ACR_RST_CONTROL;
         res_q <= ACR_RST_RESULT;
         act_ref_q <= ACR_REF_EXTERNAL;
         act_ch_q <= 4'h0;
         cyc_q <= 5'd0;
         len_q <= ACR_NORMAL_CONV_CYCLES;
         init_q <= 1'b0;
         lock_q <= 1'b0;
         gie_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         sel_q <= sel_d;
         ctl_q <= ctl_d;
         res_q <= res_d;
         act_ref_q <= act_ref_d;
         act_ch_q <= act_ch_d;
         cyc_q <= cyc_d;
         len_q <= len_d;
         init_q <= init_d;
         lock_q <= lock_d;
         gie_q <= gie_d;
         rdata_q <= rdata_d;
      end
   end
   // ****************************************
   // analog front end drive
   // ****************************************
   assign o_conv_power = ctl_q[ACR_ENABLE_BIT];
   assign o_conv_clk_tick = tick;
   assign o_conv_sample = (st_q == ACR_ST_CONV) && (cyc_q == 5'd0);
   assign o_conv_ref_sel = act_ref_q;
   // code 10 is reserved; treated like external with internal reference off
   assign o_conv_ref_internal_on = (act_ref_q == ACR_REF_INTERNAL);
   assign o_conv_channel = act_ch_q;
   assign o_conv_channel_valid = !act_ch_q[3] || act_ch_q == ACR_CH_BANDGAP
      || act_ch_q == ACR_CH_GROUND;
   assign o_conv_irq = ctl_q[ACR_DONE_BIT] && ctl_q[ACR_IRQ_EN_BIT] && gie_q;
   // ****************************************
   // checks
   // ****************************************
   sequence s_low_read;
      rd && i_paddr == ACR_OFS_RESULT_LOW;
   endsequence
   sequence s_start_write;
      st_q == ACR_ST_IDLE && wr && i_paddr == ACR_OFS_CONTROL && i_pwdata[ACR_START_BIT] && i_pwdata[ACR_ENABLE_BIT];
   endsequence
   sequence s_free_wrap;
      done_ev && ctl_q[ACR_FREE_RUN_BIT] && ctl_d[ACR_ENABLE_BIT];
   endsequence
   AST_IRQ_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      o_conv_irq == (ctl_q[4] && ctl_q[3] && gie_q))
      else $error("interrupt not gated by flag and enables");
   AST_DONE_SETS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      done_ev && ctl_q[ACR_ENABLE_BIT] |=> ctl_q[ACR_DONE_BIT])
      else $error("done flag not set on completion");
   AST_BUSY_READS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      ctl_q[ACR_START_BIT] == (st_q == ACR_ST_CONV))
      else $error("start bit does not follow busy");
   AST_DISABLE_ABORT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      wr && i_paddr == ACR_OFS_CONTROL && !i_pwdata[7] |=> st_q == ACR_ST_IDLE)
      else $error("disable did not abort conversion");
   AST_LOCK_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_low_read ##1 lock_q && !(rd && i_paddr == ACR_OFS_RESULT_HIGH) |=> $stable(res_q))
      else $error("result changed while locked");
   AST_SEL_HELD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      st_q == ACR_ST_CONV && !done_ev && ctl_d[7] |=> $stable(act_ch_q) && $stable(act_ref_q))
      else $error("selection changed mid conversion");
   AST_RESERVED_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !sel_q[4])
      else $error("reserved select bit set");
   // covers the enable written in the same access as the start
   AST_FIRST_LONG: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_start_write ##0 (init_q || !ctl_q[ACR_ENABLE_BIT]) |=> len_q == ACR_FIRST_CONV_CYCLES)
      else $error("first conversion not 25 cycles");
   AST_NORMAL_SHORT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_start_write ##0 (!init_q && ctl_q[ACR_ENABLE_BIT]) |=> len_q == ACR_NORMAL_CONV_CYCLES)
      else $error("normal conversion not 13 cycles");
   AST_START_BEGINS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_start_write |=> st_q == ACR_ST_CONV && o_conv_sample)
      else $error("start write did not begin a conversion");
   AST_START_BUSY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_start_write |=> ctl_q[ACR_START_BIT])
      else $error("start bit not set after start write");
   AST_ZERO_START_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      st_q == ACR_ST_IDLE && wr && i_paddr == ACR_OFS_CONTROL && !i_pwdata[ACR_START_BIT] |=> st_q == ACR_ST_IDLE)
      else $error("start written zero began a conversion");
   AST_SINGLE_STOPS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      done_ev && !ctl_q[ACR_FREE_RUN_BIT] |=> st_q == ACR_ST_IDLE && !ctl_q[ACR_START_BIT])
      else $error("single conversion did not stop");
   AST_FREE_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_free_wrap |=> st_q == ACR_ST_CONV && len_q == ACR_NORMAL_CONV_CYCLES && o_conv_sample)
      else $error("free running did not restart");
   AST_FREE_NEXT_SEL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_free_wrap |=> {act_ref_q, 2'b00, act_ch_q} == ($past(sel_q) & 8'hCF))
      else $error("free running did not take the new selection");
   AST_LOCK_ARM: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_low_read |=> lock_q)
      else $error("low byte read did not lock the result");
   AST_LOCK_BLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      lock_q |=> $stable(res_q))
      else $error("locked result was overwritten");
   AST_VECTOR_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_irq_vector_ack && !done_ev |=> !ctl_q[ACR_DONE_BIT])
      else $error("vector entry did not clear the flag");
   AST_W1C_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      wr && i_paddr == ACR_OFS_CONTROL && i_pwdata[ACR_DONE_BIT] && !done_ev |=> !ctl_q[ACR_DONE_BIT])
      else $error("write one did not clear the flag");
   AST_LEFT_VIEW: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      sel_q[ACR_LEFT_ALIGN_BIT] |-> view_hi == res_q[9:2] && view_lo[5:0] == 6'h00)
      else $error("left aligned view wrong");
   AST_RIGHT_VIEW: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !sel_q[ACR_LEFT_ALIGN_BIT] |-> view_hi == {6'h00, res_q[9:8]} && view_lo == res_q[7:0])
      else $error("right aligned view wrong");
endmodule

// ---- test/acr_sar_model.sv ----
/*
 analog core model: gives a code built from the latched reference and channel.
 assumes the sample level marks the first converter cycle of each conversion.
*/
module acr_sar_model (
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_power,
   input wire logic i_sample,
   input wire logic [1:0] i_ref_sel,
   input wire logic [3:0] i_channel,
   output logic [9:0] o_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // code source
   // ****************************************
   // an unpowered core toggles its output so a stale code never looks valid
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_code <= 10'h155;
      end else if (!i_power) begin
         o_code <= ~o_code;
      end else if (i_sample) begin
         o_code <= {i_ref_sel, i_channel, 4'h5};
      end
   end
endmodule

// ---- test/acr_top_tb.sv ----
/*
 bench for the converter control block: apb master tasks and scenarios.
 assumes the analog core model answers from the selection seen at sampling.
*/
module acr_top_tb
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, vack = 1'b0, serr_seen;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, prd, rd;
   logic rdy, serr, pwron, tick, samp, refi, chv, irq, samp_q;
   logic [1:0] refs;
   logic [3:0] ch;
   logic [9:0] code, c0;
   logic [7:0] tbl [6] = '{8'h00, 8'h47, 8'h89, 8'hCE, 8'h0F, 8'h4D};
   int err_count = 0, tests_run = 0, tcnt = 0;
   always #2 clk = ~clk;
   acr_top i_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr), .i_sar_code(code),
      .i_irq_vector_ack(vack), .o_conv_power(pwron), .o_conv_clk_tick(tick), .o_conv_sample(samp),
      .o_conv_ref_sel(refs), .o_conv_ref_internal_on(refi), .o_conv_channel(ch),
      .o_conv_channel_valid(chv), .o_conv_irq(irq));
   acr_sar_model i_sar (.i_sys_clk(clk), .i_arst_n(rst_n), .i_power(pwron), .i_sample(samp),
      .i_ref_sel(refs), .i_channel(ch), .o_code(code));
   // converter ticks from the sample rise up to the interrupt rise
   always @(posedge clk) begin
      samp_q <= samp;
      if (samp && !samp_q) begin
         tcnt <= int'(tick);
      end else if (tick && !irq) begin
         tcnt <= tcnt + 1;
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= {24'h00_0000, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = prd;
      serr_seen = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string n);
      apb(a, 1'b0, 8'h00);
      chk(n, {24'h00_0000, e}, rd);
   endtask
   // bounded poll: a flag that never rises shows up as a mismatch, not a hang
   task automatic wait_done();
      rd = 32'h0000_0000;
      for (int i = 0; i < 100 && rd[4] !== 1'b1; i++) apb(ACR_OFS_CONTROL, 1'b0, 8'h00);
   endtask
   function automatic logic [9:0] ex(input logic [7:0] m);
      return {m[7:6], m[3:0], 4'h5};
   endfunction
   task automatic conv(input logic [7:0] m);
      apb(ACR_OFS_INPUT_SELECT, 1'b1, m);
      // a flag left set from an earlier completion would end the poll at once
      apb(ACR_OFS_CONTROL, 1'b1, 8'hD8);
      wait_done();
      apb(ACR_OFS_CONTROL, 1'b1, 8'h98);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rdc(ACR_OFS_INPUT_SELECT, 8'h00, "select reset");
      rdc(ACR_OFS_CONTROL, 8'h00, "control reset");
      rdc(ACR_OFS_RESULT_LOW, 8'h00, "low reset");
      rdc(ACR_OFS_RESULT_HIGH, 8'h00, "high reset");
      rdc(12'h014, 8'h00, "unmapped read");
      chk("unmapped error", 32'h0000_0001, serr_seen);
      apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'hFF);
      rdc(ACR_OFS_INPUT_SELECT, 8'hEF, "reserved bit");
      $display("test reset done");
   endtask
   task automatic t_first();
      apb(ACR_OFS_INT_CTRL, 1'b1, 8'h01);
      apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'h03);
      apb(ACR_OFS_CONTROL, 1'b1, 8'hC8);
      apb(ACR_OFS_CONTROL, 1'b1, 8'h88);
      rdc(ACR_OFS_CONTROL, 8'hC8, "start held");
      wait_done();
      chk("done status", 32'h0000_0098, rd);
      chk("first length", 32'd25, tcnt);
      chk("irq on", 32'h0000_0001, irq);
      apb(ACR_OFS_CONTROL, 1'b1, 8'h98);
      @(negedge clk);
      chk("irq write clear", 32'h0000_0000, irq);
      conv(8'h03);
      chk("normal length", 32'd13, tcnt);
      apb(ACR_OFS_CONTROL, 1'b1, 8'hC8);
      wait_done();
      apb(ACR_OFS_INT_CTRL, 1'b1, 8'h00);
      @(negedge clk);
      chk("irq global off", 32'h0000_0000, irq);
      apb(ACR_OFS_INT_CTRL, 1'b1, 8'h01);
      @(posedge clk);
      vack <= 1'b1;
      @(posedge clk);
      vack <= 1'b0;
      @(negedge clk);
      chk("irq vector clear", 32'h0000_0000, irq);
      rdc(ACR_OFS_CONTROL, 8'h88, "vector clear");
      $display("test first done");
   endtask
   task automatic t_sel();
      foreach (tbl[i]) begin
         apb(ACR_OFS_INPUT_SELECT, 1'b1, tbl[i]);
         apb(ACR_OFS_CONTROL, 1'b1, 8'hC8);
         apb(ACR_OFS_INPUT_SELECT, 1'b1, ~tbl[i] & 8'hCF);
         @(negedge clk);
         chk("ref select", tbl[i][7:6], refs);
         chk("ref internal", tbl[i][7:6] == 2'b11, refi);
         chk("channel", tbl[i][3:0], ch);
         chk("channel valid", tbl[i][3:0] < 4'h8 || tbl[i][3:0] > 4'hD, chv);
         wait_done();
         apb(ACR_OFS_CONTROL, 1'b1, 8'h98);
         c0 = ex(tbl[i]);
         rdc(ACR_OFS_RESULT_LOW, c0[7:0], "low right");
         rdc(ACR_OFS_RESULT_HIGH, {6'h00, c0[9:8]}, "high right");
      end
      apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'h6D);
      rdc(ACR_OFS_RESULT_LOW, {c0[1:0], 6'h00}, "low left");
      rdc(ACR_OFS_RESULT_HIGH, c0[9:2], "high left");
      $display("test select done");
   endtask
   task automatic t_lock();
      rdc(ACR_OFS_RESULT_LOW, {c0[1:0], 6'h00}, "lock low");
      apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'h42);
      apb(ACR_OFS_CONTROL, 1'b1, 8'hC8);
      wait_done();
      chk("locked done", 32'h0000_0098, rd);
      rdc(ACR_OFS_RESULT_HIGH, {6'h00, c0[9:8]}, "locked high");
      conv(8'h42);
      c0 = ex(8'h42);
      rdc(ACR_OFS_RESULT_LOW, c0[7:0], "unlocked low");
      rdc(ACR_OFS_RESULT_HIGH, {6'h00, c0[9:8]}, "unlocked high");
      apb(ACR_OFS_CONTROL, 1'b1, 8'hC8);
      repeat (6) @(posedge clk);
      apb(ACR_OFS_CONTROL, 1'b1, 8'h00);
      @(negedge clk);
      chk("power off", 32'h0000_0000, pwron);
      repeat (80) @(posedge clk);
      rdc(ACR_OFS_CONTROL, 8'h00, "aborted");
      $display("test lock and abort done");
   endtask
   task automatic t_free();
      apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'h41);
      apb(ACR_OFS_CONTROL, 1'b1, 8'hE8);
      for (int k = 0; k < 3; k++) begin
         wait_done();
         apb(ACR_OFS_CONTROL, 1'b1, 8'hB8);
         apb(ACR_OFS_INPUT_SELECT, 1'b1, 8'h42);
         c0 = ex(k < 2 ? 8'h41 : 8'h42);
         rdc(ACR_OFS_RESULT_LOW, c0[7:0], "free low");
         rdc(ACR_OFS_RESULT_HIGH, {6'h00, c0[9:8]}, "free high");
      end
      apb(ACR_OFS_CONTROL, 1'b1, 8'h88);
      repeat (80) @(posedge clk);
      apb(ACR_OFS_CONTROL, 1'b1, 8'h98);
      repeat (80) @(posedge clk);
      rdc(ACR_OFS_CONTROL, 8'h88, "free stopped");
      $display("test free running done");
   endtask
   task automatic t_div();
      int c;
      for (int d = 0; d < 8; d++) begin
         apb(ACR_OFS_CONTROL, 1'b1, 8'h80 | 8'(d));
         for (c = 0; c < 300 && tick !== 1'b1; c++) @(negedge clk);
         @(negedge clk);
         for (c = 1; c < 300 && tick !== 1'b1; c++) @(negedge clk);
         chk("divisor", (d < 2) ? 2 : (1 << d), c);
      end
      apb(ACR_OFS_CONTROL, 1'b1, 8'h00);
      $display("test prescaler done");
   endtask
   // ****************************************
   // run
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_first();
      t_sel();
      t_lock();
      t_free();
      t_div();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end
endmodule
